//--- inc/icdma_params.svh
// constants of the i/o channel dma error and control block
// assumes msb-first register bit numbering: bit n is held in [31-n]
//
// How it works
// - bus-master error writes cause code, status bits
// - bus-master error logs address A31..A12
// - errored channel ignores requests until store clears
// - errors pulse check; extent/address parity withhold feedback
// - disabled channel access: check, no feedback
// - such access neither takes nor drives data
// - key not in mask or read-only write: 0101
// - page state 01 gives page fault 0110
// - no translation 0111, bus 1000, data parity 1001
// - address parity 1010, missing card feedback 1011
// - ecc 1100, no acknowledge 1101, reload 1110
// - internal 1111; status register fault check-stops
// - sixteen levels, level 15 processor, fifteen channels
// - slave channel has address and control words
// - privileged-key access posts interrupt, flags level 15
// - error-free slave end disables channel
// - slave error freezes channel, refuses requests and enable commands
// - disable ends transfer, keeps registers intact
// - every slave end pulses terminal count
// - status 0000 disabled, 0001 enabled, 0100 invalid op, 0101-1111 errors
`ifndef ICDMA_PARAMS_SVH
`define ICDMA_PARAMS_SVH

// ****************************************
// levels and register offsets
// ****************************************
`define ICDMA_NUM_LEVELS 16
`define ICDMA_NUM_DMA 15
`define ICDMA_PROC_LEVEL 4'hf
`define ICDMA_REG_CSR 4'h0
`define ICDMA_REG_MAR 4'h4
`define ICDMA_REG_BUF 4'h8
`define ICDMA_REG_CMD 4'hc
`define ICDMA_CMD_ENABLE 0
`define ICDMA_CMD_DISABLE 1
`define ICDMA_CSR_RESET 32'h0000_0000
`define ICDMA_MAR_RESET 32'h0000_0000

// ****************************************
// channel status fields
// ****************************************
`define ICDMA_STAT_HI 31
`define ICDMA_STAT_LO 28
`define ICDMA_SLAVE_BIT 27
`define ICDMA_DIR_BIT 24
`define ICDMA_PAGE_HI 25
`define ICDMA_PAGE_LO 6
`define ICDMA_AUTH_HI 15
`define ICDMA_AUTH_LO 8
`define ICDMA_COUNT_HI 11
`define ICDMA_COUNT_LO 0

// ****************************************
// translation word fields
// ****************************************
`define ICDMA_XW_STATE_HI 1
`define ICDMA_XW_STATE_LO 0
`define ICDMA_XW_KEY_HI 4
`define ICDMA_XW_KEY_LO 2
`define ICDMA_XW_RDONLY_BIT 5
`define ICDMA_PAGE_FAULT_STATE 2'h1

// ****************************************
// status codes
// ****************************************
`define ICDMA_ST_DISABLED 4'h0
`define ICDMA_ST_ENABLED 4'h1
`define ICDMA_ST_INVOP 4'h4
`define ICDMA_ERR_AUTH 4'h5
`define ICDMA_ERR_PAGE 4'h6
`define ICDMA_ERR_EXTENT 4'h7
`define ICDMA_ERR_IOBUS 4'h8
`define ICDMA_ERR_DPAR 4'h9
`define ICDMA_ERR_APAR 4'ha
`define ICDMA_ERR_CDSFBK 4'hb
`define ICDMA_ERR_ECC 4'hc
`define ICDMA_ERR_SYSADDR 4'hd
`define ICDMA_ERR_TCWRLD 4'he
`define ICDMA_ERR_INTERNAL 4'hf

`endif

//--- inc/icdma_pkg.sv
// types of the i/o channel dma error and control block
// assumes icdma_params.svh on the include path
`include "icdma_params.svh"

package icdma_pkg;

    typedef struct packed {
        logic io_bus;
        logic data_par;
        logic addr_par;
        logic card_fbk_miss;
        logic ecc;
        logic sys_addr_nak;
        logic xw_reload;
        logic internal;
        logic csr_fault;
    } icdma_bm_err_t;

    typedef struct packed {
        logic valid;
        logic [3:0] chan;
        logic [31:0] addr;
        logic write;
        logic to_ctrl;
        logic xw_exists;
        logic [31:0] xw;
        icdma_bm_err_t err;
    } icdma_bm_cycle_t;

    typedef struct packed {
        logic chck;
        logic sfbk_rtn;
        logic accept;
        logic data_drive;
    } icdma_bm_resp_t;

    typedef struct packed {
        logic valid;
        logic [3:0] chan;
        logic err;
        logic [3:0] err_code;
    } icdma_sl_req_t;

    typedef struct packed {
        logic [`ICDMA_NUM_LEVELS-1:0][31:0] channel_status_register;
        logic [`ICDMA_NUM_LEVELS-1:0][31:0] mar;
        logic [31:0] rdata;
        logic dsi;
        icdma_bm_resp_t bm_resp;
        logic check_stop;
        logic sl_ack;
        logic [31:0] sl_addr;
        logic sl_dir;
        logic term_pulse;
    } icdma_state_t;

endpackage

//--- logic/icdma_bm_check.sv
// bus-master cycle checker: picks the error code for one cycle
// assumes the caller has already refused disabled or errored channels
`timescale 1ns/100ps
`include "icdma_params.svh"

module icdma_bm_check (
    input wire icdma_pkg::icdma_bm_cycle_t cycle_in,
    input wire logic [31:0] csr_in,
    output logic [3:0] code_out,
    output logic quiet_sfbk_out
);
    import icdma_pkg::*;

    logic [2:0] key;
    logic [7:0] mask;

    // ****************************************
    // priority encoder
    // ****************************************
    // internal, reload, address parity and existence faults first: a bad translation word makes later checks meaningless
    always_comb begin
        key = cycle_in.xw[`ICDMA_XW_KEY_HI:`ICDMA_XW_KEY_LO];
        mask = csr_in[`ICDMA_AUTH_HI:`ICDMA_AUTH_LO];
        code_out = `ICDMA_ST_DISABLED;
        if (cycle_in.err.internal) begin
            code_out = `ICDMA_ERR_INTERNAL;
        end else if (cycle_in.err.xw_reload) begin
            code_out = `ICDMA_ERR_TCWRLD;
        end else if (cycle_in.err.addr_par) begin
            code_out = `ICDMA_ERR_APAR;
        end else if (!cycle_in.xw_exists) begin
            code_out = `ICDMA_ERR_EXTENT;
        end else if (cycle_in.xw[`ICDMA_XW_STATE_HI:`ICDMA_XW_STATE_LO] == `ICDMA_PAGE_FAULT_STATE) begin
            code_out = `ICDMA_ERR_PAGE;
        end else if (!mask[7 - key] || (cycle_in.write && cycle_in.xw[`ICDMA_XW_RDONLY_BIT])) begin
            code_out = `ICDMA_ERR_AUTH;
        end else if (cycle_in.err.data_par && cycle_in.write) begin
            code_out = `ICDMA_ERR_DPAR;
        end else if (cycle_in.err.ecc) begin
            code_out = `ICDMA_ERR_ECC;
        end else if (cycle_in.err.sys_addr_nak) begin
            code_out = `ICDMA_ERR_SYSADDR;
        end else if (cycle_in.err.card_fbk_miss) begin
            code_out = `ICDMA_ERR_CDSFBK;
        end else if (cycle_in.err.io_bus) begin
            code_out = `ICDMA_ERR_IOBUS;
        end
        quiet_sfbk_out = (code_out == `ICDMA_ERR_EXTENT) || (code_out == `ICDMA_ERR_APAR);
    end

endmodule

//--- logic/icdma_ctrl.sv
// i/o channel controller dma channel control and error handling
// assumes same-clock request sources and a single-cycle register port
`timescale 1ns/100ps
`include "icdma_params.svh"

module icdma_ctrl #(
    parameter int NUM_DMA = `ICDMA_NUM_DMA
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic priv_key_in,
    output logic [31:0] reg_rdata_out,
    output logic data_storage_int_out,
    input wire icdma_pkg::icdma_bm_cycle_t bm_cycle_in,
    output icdma_pkg::icdma_bm_resp_t bm_resp_out,
    output logic check_stop_out,
    input wire icdma_pkg::icdma_sl_req_t sl_req_in,
    output logic sl_ack_out,
    output logic [31:0] sl_mem_addr_out,
    output logic sl_dir_out,
    output logic terminal_count_pulse_out
);
    import icdma_pkg::*;

    icdma_state_t s;
    icdma_state_t next_s;

    logic [3:0] bm_code;
    logic bm_quiet_sfbk;

    // ****************************************
    // bus-master error classifier
    // ****************************************
    icdma_bm_check u_check (
        .cycle_in(bm_cycle_in),
        .csr_in(s.channel_status_register[bm_cycle_in.chan]),
        .code_out(bm_code),
        .quiet_sfbk_out(bm_quiet_sfbk)
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [3:0] stat_of(input logic [31:0] channel_status_register);
        stat_of = channel_status_register[`ICDMA_STAT_HI:`ICDMA_STAT_LO];
    endfunction

    // level 15 and unbuilt channels never run
    function automatic logic usable(input logic [3:0] ch);
        usable = (ch != `ICDMA_PROC_LEVEL) && (32'(ch) < NUM_DMA);
    endfunction

    function automatic logic is_enabled(input logic [31:0] channel_status_register);
        is_enabled = stat_of(channel_status_register) == `ICDMA_ST_ENABLED;
    endfunction

    function automatic logic has_error(input logic [31:0] channel_status_register);
        has_error = channel_status_register[`ICDMA_STAT_HI:`ICDMA_STAT_HI-1] != 2'h0;
    endfunction

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        logic [3:0] rch;
        logic [3:0] rreg;
        logic [3:0] bch;
        logic [3:0] sch;
        logic [31:0] csr_w;
        logic [11:0] count;
        logic acc;
        rch = reg_addr_in[7:4];
        rreg = reg_addr_in[3:0];
        bch = bm_cycle_in.chan;
        sch = sl_req_in.chan;
        csr_w = `ICDMA_CSR_RESET;
        count = 12'h000;
        acc = reg_wr_in || reg_rd_in;
        next_s = s;
        next_s.rdata = 32'h0000_0000;
        next_s.dsi = 1'b0;
        next_s.bm_resp = '0;
        next_s.sl_ack = 1'b0;
        next_s.term_pulse = 1'b0;

        // ****************************************
        // register port
        // ****************************************
        // privileged key blocks every access
        if (acc && priv_key_in) begin
            next_s.dsi = 1'b1;
            next_s.channel_status_register[`ICDMA_PROC_LEVEL][`ICDMA_STAT_HI:`ICDMA_STAT_LO] = `ICDMA_ST_INVOP;
        end else if (reg_rd_in) begin
            unique case (rreg)
                `ICDMA_REG_CSR: next_s.rdata = s.channel_status_register[rch];
                `ICDMA_REG_MAR: next_s.rdata = s.mar[rch];
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end else if (reg_wr_in) begin
            unique case (rreg)
                // a store is the only way to clear an error
                `ICDMA_REG_CSR: next_s.channel_status_register[rch] = reg_wdata_in;
                `ICDMA_REG_MAR: next_s.mar[rch] = reg_wdata_in;
                `ICDMA_REG_CMD: begin
                    csr_w = s.channel_status_register[rch];
                    if (reg_wdata_in[`ICDMA_CMD_ENABLE] && usable(rch)
                            && stat_of(csr_w) == `ICDMA_ST_DISABLED) begin
                        next_s.channel_status_register[rch][`ICDMA_STAT_HI:`ICDMA_STAT_LO] = `ICDMA_ST_ENABLED;
                    // soft stop keeps address and count
                    end else if (reg_wdata_in[`ICDMA_CMD_DISABLE] && is_enabled(csr_w)) begin
                        next_s.channel_status_register[rch][`ICDMA_STAT_HI:`ICDMA_STAT_LO] = `ICDMA_ST_DISABLED;
                        if (csr_w[`ICDMA_SLAVE_BIT]) begin
                            next_s.term_pulse = 1'b1;
                        end
                    end
                end
                default: begin
                    // buffer control is absent in this build: stores vanish
                end
            endcase
        end

        // ****************************************
        // bus-master cycles
        // ****************************************
        // hardware events come after the store so a same-cycle error wins
        if (bm_cycle_in.valid) begin
            csr_w = next_s.channel_status_register[bch];
            if (bm_cycle_in.err.csr_fault) begin
                next_s.check_stop = 1'b1;
            end
            // refused channel: level 15, unbuilt, slave, disabled or errored
            if (!usable(bch) || csr_w[`ICDMA_SLAVE_BIT] || !is_enabled(s.channel_status_register[bch])) begin
                next_s.bm_resp.chck = 1'b1;
                next_s.bm_resp.sfbk_rtn = 1'b0;
            end else if (bm_code != `ICDMA_ST_DISABLED) begin
                next_s.channel_status_register[bch][`ICDMA_STAT_HI:`ICDMA_STAT_LO] = bm_code;
                next_s.channel_status_register[bch][`ICDMA_PAGE_HI:`ICDMA_PAGE_LO] = bm_cycle_in.addr[31:12];
                next_s.bm_resp.chck = 1'b1;
                next_s.bm_resp.sfbk_rtn = !bm_quiet_sfbk;
            end else begin
                next_s.bm_resp.sfbk_rtn = 1'b1;
                next_s.bm_resp.accept = 1'b1;
                next_s.bm_resp.data_drive = bm_cycle_in.to_ctrl && !bm_cycle_in.write;
            end
        end

        // ****************************************
        // dma-slave requests
        // ****************************************
        if (sl_req_in.valid) begin
            csr_w = next_s.channel_status_register[sch];
            // errored or idle channel refuses requests
            if (usable(sch) && csr_w[`ICDMA_SLAVE_BIT] && is_enabled(s.channel_status_register[sch])
                    && is_enabled(csr_w)) begin
                if (sl_req_in.err) begin
                    next_s.channel_status_register[sch][`ICDMA_STAT_HI:`ICDMA_STAT_LO] = sl_req_in.err_code;
                    next_s.term_pulse = 1'b1;
                end else begin
                    next_s.sl_ack = 1'b1;
                    next_s.sl_addr = next_s.mar[sch];
                    next_s.sl_dir = csr_w[`ICDMA_DIR_BIT];
                    next_s.mar[sch] = next_s.mar[sch] + 32'h0000_0001;
                    count = csr_w[`ICDMA_COUNT_HI:`ICDMA_COUNT_LO];
                    if (count == 12'h000) begin
                        next_s.channel_status_register[sch][`ICDMA_STAT_HI:`ICDMA_STAT_LO] = `ICDMA_ST_DISABLED;
                        next_s.term_pulse = 1'b1;
                    end else begin
                        next_s.channel_status_register[sch][`ICDMA_COUNT_HI:`ICDMA_COUNT_LO] = count - 12'h001;
                    end
                end
            end
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < `ICDMA_NUM_LEVELS; i++) begin
                s.channel_status_register[i] <= `ICDMA_CSR_RESET;
                s.mar[i] <= `ICDMA_MAR_RESET;
            end
            s.rdata <= 32'h0000_0000;
            s.dsi <= 1'b0;
            s.bm_resp <= '0;
            s.check_stop <= 1'b0;
            s.sl_ack <= 1'b0;
            s.sl_addr <= 32'h0000_0000;
            s.sl_dir <= 1'b0;
            s.term_pulse <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata_out = s.rdata;
    assign data_storage_int_out = s.dsi;
    assign bm_resp_out = s.bm_resp;
    assign check_stop_out = s.check_stop;
    assign sl_ack_out = s.sl_ack;
    assign sl_mem_addr_out = s.sl_addr;
    assign sl_dir_out = s.sl_dir;
    assign terminal_count_pulse_out = s.term_pulse;

endmodule

//--- tb/icdma_ctrl_sva.sv
// port assertions for the channel dma error and control block
// assumes one clock, bound to every icdma_ctrl instance
`timescale 1ns/100ps

module icdma_ctrl_sva #(
    parameter int NUM_DMA = 15
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic priv_key_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic data_storage_int_out,
    input wire icdma_pkg::icdma_bm_cycle_t bm_cycle_in,
    input wire icdma_pkg::icdma_bm_resp_t bm_resp_out,
    input wire logic check_stop_out,
    input wire icdma_pkg::icdma_sl_req_t sl_req_in,
    input wire logic sl_ack_out
);
    import icdma_pkg::*;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    // ****************************************
    // bus-master answers
    // ****************************************
    sequence s_refuse;
        bm_resp_out.chck && !bm_resp_out.sfbk_rtn && !bm_resp_out.accept && !bm_resp_out.data_drive;
    endsequence
    sequence s_bad_chan;
        bm_cycle_in.valid && bm_cycle_in.chan >= NUM_DMA;
    endsequence
    a_bad_chan: assert property (s_bad_chan |=> s_refuse)
        else $error("unusable channel answered");
    a_chck_cause: assert property (bm_resp_out.chck |-> $past(bm_cycle_in.valid))
        else $error("check pulse without a cycle");
    a_answer_each: assert property (bm_cycle_in.valid |=> bm_resp_out.chck || bm_resp_out.sfbk_rtn)
        else $error("cycle left unanswered");
    a_no_data_chck: assert property (bm_resp_out.chck |-> !bm_resp_out.accept && !bm_resp_out.data_drive)
        else $error("data moved on check");
    a_stop_cause: assert property (bm_cycle_in.valid && bm_cycle_in.err.csr_fault |=> check_stop_out)
        else $error("status fault did not stop");
    a_stop_sticky: assert property (check_stop_out |=> check_stop_out)
        else $error("check stop dropped");

    // ****************************************
    // register port and slave side
    // ****************************************
    a_dsi_key: assert property ((reg_wr_in || reg_rd_in) && priv_key_in |=> data_storage_int_out && reg_rdata_out == 32'h0)
        else $error("privileged access not refused");
    a_dsi_cause: assert property (data_storage_int_out |-> $past((reg_wr_in || reg_rd_in) && priv_key_in))
        else $error("spurious storage interrupt");
    a_rdata_slot: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside its slot");
    a_slave_err: assert property (sl_req_in.valid && sl_req_in.err |=> !sl_ack_out)
        else $error("errored transfer acknowledged");
    a_ack_cause: assert property (sl_ack_out |-> $past(sl_req_in.valid && !sl_req_in.err))
        else $error("acknowledge without request");
endmodule

bind icdma_ctrl icdma_ctrl_sva #(.NUM_DMA(NUM_DMA)) icdma_ctrl_sva_inst (.ref_clk_in, .rst_n_in, .reg_wr_in,
    .reg_rd_in, .priv_key_in, .reg_rdata_out, .data_storage_int_out, .bm_cycle_in, .bm_resp_out, .check_stop_out,
    .sl_req_in, .sl_ack_out);

//--- tb/icdma_adapter_model.sv
// adapter side model: reacts to check and terminal count
// assumes the bench issues the bus cycles itself
`timescale 1ns/100ps

module icdma_adapter_model (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire icdma_pkg::icdma_bm_resp_t bm_resp_in,
    input wire logic terminal_count_pulse_in,
    output logic suspended_out,
    output logic dev_int_out
);
    import icdma_pkg::*;
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            suspended_out <= 1'b0;
            dev_int_out <= 1'b0;
        end else begin
            if (bm_resp_in.chck && !bm_resp_in.sfbk_rtn) begin
                suspended_out <= 1'b1;
            end
            dev_int_out <= terminal_count_pulse_in || (bm_resp_in.chck && !bm_resp_in.sfbk_rtn);
        end
    end
endmodule

//--- tb/icdma_ctrl_tb.sv
// self-checking bench for icdma_ctrl
// assumes default NUM_DMA and a 40 MHz clock
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin $display("mismatch %s exp %h got %h", nm, ex, gt); err_count++; end end

module icdma_ctrl_tb;
    import icdma_pkg::*;
    typedef struct packed {
        logic [8:0] e;
        logic ex;
        logic [5:0] t;
        logic w;
        logic [3:0] code;
        logic fb;
    } icdma_row_t;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic priv_key_in = 1'b0;
    logic [31:0] reg_rdata_out;
    logic data_storage_int_out;
    icdma_bm_cycle_t bm_cycle_in = '0;
    icdma_bm_resp_t bm_resp_out;
    logic check_stop_out;
    icdma_sl_req_t sl_req_in = '0;
    logic sl_ack_out;
    logic [31:0] sl_mem_addr_out;
    logic sl_dir_out;
    logic terminal_count_pulse_out;
    logic suspended;
    logic dev_int;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int n_int = 0;
    logic [31:0] rd;
    logic [34:0] sr;
    icdma_bm_resp_t rsp;
    // ****************************************
    // error table: mask permits keys 1..7
    // ****************************************
    icdma_row_t rows [14] = '{'{9'h0, 1'b1, 6'h04, 1'b0, 4'h1, 1'b1}, '{9'h0, 1'b1, 6'h00, 1'b0, 4'h5, 1'b1},
        '{9'h0, 1'b1, 6'h24, 1'b1, 4'h5, 1'b1}, '{9'h0, 1'b1, 6'h05, 1'b0, 4'h6, 1'b1},
        '{9'h0, 1'b0, 6'h04, 1'b0, 4'h7, 1'b0}, '{9'h100, 1'b1, 6'h04, 1'b0, 4'h8, 1'b1},
        '{9'h080, 1'b1, 6'h04, 1'b1, 4'h9, 1'b1}, '{9'h040, 1'b1, 6'h04, 1'b0, 4'ha, 1'b0},
        '{9'h020, 1'b1, 6'h04, 1'b0, 4'hb, 1'b1}, '{9'h010, 1'b1, 6'h04, 1'b0, 4'hc, 1'b1},
        '{9'h008, 1'b1, 6'h04, 1'b0, 4'hd, 1'b1}, '{9'h004, 1'b1, 6'h04, 1'b0, 4'he, 1'b1},
        '{9'h002, 1'b1, 6'h04, 1'b0, 4'hf, 1'b1}, '{9'h140, 1'b1, 6'h04, 1'b0, 4'ha, 1'b0}};

    icdma_ctrl icdma_ctrl_inst (.ref_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .priv_key_in, .reg_rdata_out, .data_storage_int_out, .bm_cycle_in, .bm_resp_out, .check_stop_out,
        .sl_req_in, .sl_ack_out, .sl_mem_addr_out, .sl_dir_out, .terminal_count_pulse_out);
    icdma_adapter_model icdma_adapter_model_inst (.ref_clk_in, .rst_n_in, .bm_resp_in(bm_resp_out),
        .terminal_count_pulse_in(terminal_count_pulse_out), .suspended_out(suspended), .dev_int_out(dev_int));

    always #12.5 ref_clk_in = ~ref_clk_in;
    // run is about 200 cycles; ceiling leaves wide margin
    always @(posedge ref_clk_in) begin
        cycles++;
        if (dev_int === 1'b1) n_int++;
        if (cycles == 20000) begin
            err_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1 rd = reg_rdata_out;
    endtask
    task automatic bm(input logic [3:0] ch, input icdma_row_t r);
        icdma_bm_cycle_t c;
        c = '0;
        c.valid = 1'b1;
        c.chan = ch;
        c.addr = 32'habcde123;
        c.write = r.w;
        c.to_ctrl = 1'b1;
        c.xw_exists = r.ex;
        c.xw = {26'h0, r.t};
        c.err = r.e;
        @(posedge ref_clk_in);
        bm_cycle_in <= c;
        @(posedge ref_clk_in);
        bm_cycle_in <= '0;
        #1 rsp = bm_resp_out;
    endtask
    task automatic sl(input logic e, input logic [3:0] code);
        @(posedge ref_clk_in);
        sl_req_in <= '{1'b1, 4'h3, e, code};
        @(posedge ref_clk_in);
        sl_req_in <= '0;
        #1 sr = {sl_ack_out, terminal_count_pulse_out, sl_mem_addr_out, sl_dir_out};
    endtask

    initial begin
        repeat (5) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rdr(8'h20);
        `CHK("csr_reset", 32'h0, rd)
        bm(4'h2, rows[0]);
        `CHK("never_enabled", 4'h8, rsp)
        for (int i = 0; i < 14; i++) begin
            wr(8'h20, 32'h0000_7f00);
            wr(8'h2c, 32'h1);
            bm(4'h2, rows[i]);
            `CHK("bm_resp", rows[i].code == 4'h1 ? 4'h7 : {1'b1, rows[i].fb, 2'b00}, rsp)
            rdr(8'h20);
            `CHK("err_code", rows[i].code, rd[31:28])
            if (rows[i].code != 4'h1) `CHK("page_log", 20'habcde, rd[25:6])
            bm(4'h2, rows[0]);
            `CHK("after_err", rows[i].code == 4'h1 ? 4'h7 : 4'h8, rsp)
        end
        @(posedge ref_clk_in);
        priv_key_in <= 1'b1;
        rdr(8'h20);
        `CHK("priv_data", 32'h0, rd)
        `CHK("priv_dsi", 1'b1, data_storage_int_out)
        priv_key_in <= 1'b0;
        rdr(8'hf0);
        `CHK("invalid_op", 4'h4, rd[31:28])
        // ****************************************
        // slave channel: slave flag, count 1
        // ****************************************
        // slave flag set for slave channel
        wr(8'h30, 32'h0900_0001);
        wr(8'h34, 32'h0000_1000);
        wr(8'h3c, 32'h1);
        sl(1'b0, 4'h0);
        `CHK("slave_1", {2'b10, 32'h1000, 1'b1}, sr)
        sl(1'b0, 4'h0);
        `CHK("slave_end", {2'b11, 32'h1001, 1'b1}, sr)
        rdr(8'h30);
        `CHK("end_status", 4'h0, rd[31:28])
        sl(1'b0, 4'h0);
        `CHK("after_end", 2'b00, sr[34:33])
        wr(8'h30, 32'h0900_0005);
        wr(8'h3c, 32'h1);
        sl(1'b1, 4'h8);
        `CHK("slave_err", 2'b01, sr[34:33])
        wr(8'h3c, 32'h1);
        rdr(8'h30);
        `CHK("err_frozen", 4'h8, rd[31:28])
        sl(1'b0, 4'h0);
        `CHK("err_refuse", 2'b00, sr[34:33])
        rdr(8'h34);
        `CHK("mar_frozen", 32'h1002, rd)
        wr(8'h30, 32'h0900_0005);
        wr(8'h3c, 32'h1);
        wr(8'h3c, 32'h2);
        #1 `CHK("disable_tc", 1'b1, terminal_count_pulse_out)
        rdr(8'h30);
        `CHK("disable_keep", 32'h0900_0005, rd)
        repeat (3) @(posedge ref_clk_in);
        // 17 check-alone answers plus 3 terminal counts
        `CHK("dev_int", 20, n_int)
        bm(4'hf, rows[0]);
        `CHK("proc_level", 4'h8, rsp)
        `CHK("suspended", 1'b1, suspended)
        bm(4'h2, '{9'h001, 1'b1, 6'h04, 1'b0, 4'h0, 1'b0});
        `CHK("check_stop", 1'b1, check_stop_out)
        end_sim();
    end
endmodule
